// File: hdl/bfm_fault_manager.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// R1 - active open-load check off after reset, enabled by a control-four bit
// R2 - flag a miss when no overshoot seen between low-side off and high-side on
// R3 - report open load only after three consecutive misses; a hit restarts
// R4 - controller keeps active open-load off during low-side recirculation braking
// R5 - pin variant: disable pin high turns off active and passive open-load checks
// R6 - over-temperature disables bridge, pulls fault pin, latches flags, pump stays on
// R7 - latched thermal mode holds off until condition ends and clear request
// R8 - auto thermal mode resumes on cooling; thermal flag held until clear
// R9 - thermal mode defaults latched for serial, auto for pin variant
// R10 - warning sets flag only, and clears itself when temperature drops
// R11 - warning-report bit also routes warning to fault pin and summary flag
// R12 - pump undervoltage reports and forces hi-z unless disabled; auto recovery
// R13 - overcurrent mode: latched, retry after timeout, report only, or off
// R14 - detected open load holds fault pin low until a clear request
// R15 - sleep low pulse within deglitch and 20 us window clears latched faults
// R16 - fault pin is OR of all reported conditions and latched reportable flags
// R17 - clear resets only latched flags whose condition has ended
module bfm_fault_manager #(
  parameter bit PIN_VARIANT = 1'b0,
  parameter int RETRY_CYCLES = bfm_pkg::RETRY_CYC,
  parameter int DEGLITCH_CYCLES = bfm_pkg::DEGLITCH_CYC,
  parameter int PULSE_MAX_CYCLES = bfm_pkg::PULSE_MAX_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic sleep_in_n,
  input wire logic openload_disable_pin,
  input wire logic pwm_pulse_done,
  input wire logic overshoot_seen,
  input wire logic passive_openload_detect,
  input wire logic over_temp,
  input wire logic over_temp_warn,
  input wire logic over_current,
  input wire logic pump_undervoltage,
  input wire logic supply_undervoltage,
  output logic fault_out_n,
  output logic bridge_hiz,
  output logic pump_enable,
  output logic active_openload_check,
  output logic passive_openload_check,
  output logic irq
);
  initial begin
    if (RETRY_CYCLES < 1 || RETRY_CYCLES > 2**27) begin
      $error("bfm_fault_manager: RETRY_CYCLES out of range");
    end
  end

  logic [7:0] config_reg;
  logic [7:0] ctrl_four;
  logic [bfm_pkg::NFLAGS-1:0] flags;
  logic [bfm_pkg::NFLAGS-1:0] mask;
  logic [bfm_pkg::NFLAGS-1:0] irq_status;
  logic [26:0] retry_cnt;
  logic ocp_active;
  logic clear_bit_pulse;

  wire wr_status = reg_write && (reg_addr == bfm_pkg::ADDR_STATUS);
  wire wr_mask = reg_write && (reg_addr == bfm_pkg::ADDR_MASK);
  wire wr_config = reg_write && (reg_addr == bfm_pkg::ADDR_CONFIG);
  wire wr_ctrl4 = reg_write && (reg_addr == bfm_pkg::ADDR_CTRL4);

  // pin variant: thermal auto, pump check always on, overcurrent latched
  wire thermal_mode_sel = PIN_VARIANT ? bfm_pkg::TSD_AUTO
                                      : config_reg[bfm_pkg::C_THERMAL_MODE_SEL]; // [R9]
  wire warning_report_enable = PIN_VARIANT ? 1'b0 : config_reg[bfm_pkg::C_WARNING_REPORT_ENABLE];
  wire pump_uv_check_disable = PIN_VARIANT ? 1'b0 : config_reg[bfm_pkg::C_PUMP_UV_CHECK_DISABLE];
  wire [1:0] ocp_mode = PIN_VARIANT ? bfm_pkg::OCP_LATCHED
                        : config_reg[bfm_pkg::C_OCP_HI:bfm_pkg::C_OCP_LO]; // [R13]
  wire active_openload_enable = PIN_VARIANT ? !openload_disable_pin
                                : ctrl_four[bfm_pkg::C4_OLA_EN]; // [R1] [R5]
  wire passive_openload_enable = PIN_VARIANT ? !openload_disable_pin : 1'b1; // [R5]

  logic sleep_clear;
  wire clear_req = sleep_clear || clear_bit_pulse; // [R15]

  logic ola_detect;
  bfm_ola_counter #(
    .COUNT(bfm_pkg::OLA_FAIL_COUNT)
  ) u_ola (
    .clock(clock),
    .rst(rst),
    .enable(active_openload_enable),
    .pulse_done(pwm_pulse_done),
    .overshoot_seen(overshoot_seen),
    .detect(ola_detect)
  );

  bfm_sleep_pulse #(
    .MIN_CYC(DEGLITCH_CYCLES),
    .MAX_CYC(PULSE_MAX_CYCLES)
  ) u_sleep (
    .clock(clock),
    .rst(rst),
    .sleep_in_n(sleep_in_n),
    .clear_pulse(sleep_clear)
  );

  wire ocp_event = over_current && (ocp_mode != bfm_pkg::OCP_OFF);
  wire pump_event = pump_undervoltage && !pump_uv_check_disable; // [R12]
  wire old_event = ola_detect || (passive_openload_detect && passive_openload_enable);

  // set wins over clear; clear only drops flags whose cause is gone
  wire [bfm_pkg::NFLAGS-1:0] cond;
  assign cond[bfm_pkg::F_OLD] = old_event;
  assign cond[bfm_pkg::F_TSD] = over_temp;
  assign cond[bfm_pkg::F_OCP] = ocp_event;
  assign cond[bfm_pkg::F_PUMP_UNDERVOLTAGE_FLAG] = pump_event;
  assign cond[bfm_pkg::F_SUPPLY_UNDERVOLTAGE_FLAG] = supply_undervoltage;
  assign cond[bfm_pkg::F_OTW] = over_temp_warn;
  assign cond[bfm_pkg::F_FAULT] = 1'b0;

  wire tsd_hold = flags[bfm_pkg::F_TSD] && (thermal_mode_sel == bfm_pkg::TSD_LATCHED);
  wire ocp_hold = flags[bfm_pkg::F_OCP] && (ocp_mode == bfm_pkg::OCP_LATCHED
                  || ocp_mode == bfm_pkg::OCP_REPORT);
  wire ocp_off_bridge = (ocp_mode == bfm_pkg::OCP_LATCHED && flags[bfm_pkg::F_OCP])
                        || (ocp_mode == bfm_pkg::OCP_RETRY && ocp_active);
  wire warn_reported = over_temp_warn && warning_report_enable; // [R11]

  wire fault_any = over_temp || tsd_hold // [R6] [R7] [R8]
                   || ocp_event || ocp_hold || (ocp_mode == bfm_pkg::OCP_RETRY && ocp_active)
                   || flags[bfm_pkg::F_OLD] || old_event // [R14]
                   || pump_event || supply_undervoltage
                   || warn_reported; // [R16]

  wire next_hiz = over_temp || tsd_hold // [R6] [R7]
                  || pump_event // [R12]
                  || supply_undervoltage || ocp_off_bridge; // [R13]

  wire [bfm_pkg::NFLAGS-1:0] latched;
  wire [bfm_pkg::NFLAGS-1:0] next_flags;
  genvar gi;
  generate
    for (gi = 0; gi < bfm_pkg::NFLAGS; gi = gi + 1) begin : g_flag
      if (gi == bfm_pkg::F_OTW) begin : g_live
        assign latched[gi] = 1'b0;
        assign next_flags[gi] = cond[gi]; // [R10]
      end else if (gi == bfm_pkg::F_FAULT) begin : g_sum
        assign latched[gi] = 1'b0;
        assign next_flags[gi] = fault_any;
      end else begin : g_latch
        assign latched[gi] = flags[gi] && !(clear_req && !cond[gi]); // [R17]
        assign next_flags[gi] = cond[gi] || latched[gi];
      end
    end
  endgenerate

  wire [bfm_pkg::NFLAGS-1:0] rising = next_flags & ~flags;
  wire [bfm_pkg::NFLAGS-1:0] w1c = wr_status ? reg_wdata[bfm_pkg::NFLAGS-1:0]
                                             : {bfm_pkg::NFLAGS{1'b0}};
  wire [bfm_pkg::NFLAGS-1:0] next_irq_status = rising | (irq_status & ~w1c);

  wire retry_done = (retry_cnt == 27'h0000001);
  wire [26:0] next_retry = (ocp_mode != bfm_pkg::OCP_RETRY) ? 27'h0
                           : over_current ? 27'(RETRY_CYCLES)
                           : (retry_cnt != 27'h0) ? retry_cnt - 27'h1 : 27'h0;
  wire next_ocp_active = (ocp_mode == bfm_pkg::OCP_RETRY)
                         && (over_current || (ocp_active && !retry_done)); // [R13]

  wire [7:0] rd_value = (reg_addr == bfm_pkg::ADDR_STATUS) ? {1'b0, irq_status}
                      : (reg_addr == bfm_pkg::ADDR_MASK) ? {1'b0, mask}
                      : (reg_addr == bfm_pkg::ADDR_CONFIG) ? config_reg
                      : (reg_addr == bfm_pkg::ADDR_CTRL4) ? ctrl_four
                      : (reg_addr == bfm_pkg::ADDR_COND) ? {1'b0, flags}
                      : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      config_reg <= bfm_pkg::CONFIG_RESET;
      ctrl_four <= bfm_pkg::CTRL4_RESET; // [R1]
      mask <= {bfm_pkg::NFLAGS{1'b0}};
      clear_bit_pulse <= 1'b0;
    end else begin
      if (wr_config) begin
        config_reg <= {1'b0, reg_wdata[6:0]};
      end
      if (wr_ctrl4) begin
        ctrl_four <= reg_wdata;
      end
      if (wr_mask) begin
        mask <= reg_wdata[bfm_pkg::NFLAGS-1:0];
      end
      clear_bit_pulse <= wr_config && reg_wdata[bfm_pkg::C_CLR];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= {bfm_pkg::NFLAGS{1'b0}};
      irq_status <= {bfm_pkg::NFLAGS{1'b0}};
      retry_cnt <= 27'h0;
      ocp_active <= 1'b0;
    end else begin
      flags <= next_flags;
      irq_status <= next_irq_status;
      retry_cnt <= next_retry;
      ocp_active <= next_ocp_active;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fault_out_n <= 1'b1;
      bridge_hiz <= 1'b0;
      pump_enable <= 1'b1;
      active_openload_check <= 1'b0;
      passive_openload_check <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      fault_out_n <= !fault_any; // [R16]
      bridge_hiz <= next_hiz;
      pump_enable <= 1'b1; // [R6]
      active_openload_check <= active_openload_enable;
      passive_openload_check <= passive_openload_enable;
      irq <= |(next_irq_status & mask);
      reg_rdata <= reg_read ? rd_value : 8'h00;
    end
  end
endmodule

// File: hdl/bfm_ola_counter.sv
`timescale 1ns/1ps
module bfm_ola_counter #(
  parameter int COUNT = bfm_pkg::OLA_FAIL_COUNT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic pulse_done,
  input wire logic overshoot_seen,
  output logic detect
);
  initial begin
    if (COUNT < 1 || COUNT > 255) begin
      $error("bfm_ola_counter: COUNT out of range");
    end
  end
  logic [7:0] fails;
  wire miss = pulse_done && !overshoot_seen;
  wire hit = miss && (fails == 8'(COUNT - 1));
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      fails <= 8'h00;
      detect <= 1'b0;
    end else if (pulse_done) begin
      fails <= (miss && !hit) ? fails + 8'h01 : 8'h00; // [R2] [R3]
      detect <= hit; // [R3]
    end else begin
      detect <= 1'b0;
    end
  end
endmodule

// File: hdl/bfm_pkg.sv
package bfm_pkg;
  // thermal mode encodings
  localparam logic TSD_LATCHED = 1'b0;
  localparam logic TSD_AUTO = 1'b1;
  // overcurrent mode encodings
  localparam logic [1:0] OCP_LATCHED = 2'h0;
  localparam logic [1:0] OCP_RETRY = 2'h1;
  localparam logic [1:0] OCP_REPORT = 2'h2;
  localparam logic [1:0] OCP_OFF = 2'h3;
  // open-load consecutive failure count
  localparam int OLA_FAIL_COUNT = 3;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int SLEEP_DEGLITCH_US = 5;
  localparam int SLEEP_PULSE_MAX_US = 20;
  localparam int RETRY_US = 4000;
  localparam int DEGLITCH_CYC = SLEEP_DEGLITCH_US * CLK_MHZ;
  localparam int PULSE_MAX_CYC = SLEEP_PULSE_MAX_US * CLK_MHZ;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  // register offsets
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_CTRL4 = 4'h3;
  localparam logic [3:0] ADDR_COND = 4'h4;
  // flag bit positions (status, mask, cond share this layout)
  localparam int F_OLD = 0;
  localparam int F_TSD = 1;
  localparam int F_OCP = 2;
  localparam int F_PUMP_UNDERVOLTAGE_FLAG = 3;
  localparam int F_SUPPLY_UNDERVOLTAGE_FLAG = 4;
  localparam int F_OTW = 5;
  localparam int F_FAULT = 6;
  localparam int NFLAGS = 7;
  // config bit positions
  localparam int C_THERMAL_MODE_SEL = 0;
  localparam int C_WARNING_REPORT_ENABLE = 1;
  localparam int C_PUMP_UV_CHECK_DISABLE = 2;
  localparam int C_OCP_LO = 3;
  localparam int C_OCP_HI = 4;
  localparam int C_CLR = 7;
  // control four bit positions
  localparam int C4_OLA_EN = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CTRL4_RESET = 8'h00;
endpackage

// File: hdl/bfm_sleep_pulse.sv
`timescale 1ns/1ps
module bfm_sleep_pulse #(
  parameter int MIN_CYC = bfm_pkg::DEGLITCH_CYC,
  parameter int MAX_CYC = bfm_pkg::PULSE_MAX_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sleep_in_n,
  output logic clear_pulse
);
  initial begin
    if (MIN_CYC < 1 || MAX_CYC <= MIN_CYC || MAX_CYC > 65000) begin
      $error("bfm_sleep_pulse: bad pulse window");
    end
  end
  logic [15:0] low_cnt;
  logic prev_n;
  wire rise = sleep_in_n && !prev_n;
  wire in_window = (low_cnt > 16'(MIN_CYC)) && (low_cnt < 16'(MAX_CYC));
  always_ff @(posedge clock) begin
    if (rst) begin
      low_cnt <= 16'h0000;
      prev_n <= 1'b1;
      clear_pulse <= 1'b0;
    end else begin
      prev_n <= sleep_in_n;
      clear_pulse <= rise && in_window; // [R15]
      if (sleep_in_n) begin
        low_cnt <= 16'h0000;
      end else if (low_cnt != 16'hffff) begin
        low_cnt <= low_cnt + 16'h0001;
      end
    end
  end
endmodule

// File: verif/bfm_fault_manager_bench.sv
`timescale 1ns/1ps
module bfm_fault_manager_bench;
  localparam logic [3:0] CFG = bfm_pkg::ADDR_CONFIG, CND = bfm_pkg::ADDR_COND;
  logic clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, go = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, len = 8'h00;
  logic openload_disable_pin = 1'b1, pwm_pulse_done = 1'b0, overshoot_seen = 1'b0;
  logic passive_openload_detect = 1'b0, over_temp = 1'b0, over_temp_warn = 1'b0;
  logic over_current = 1'b0, pump_undervoltage = 1'b0, supply_undervoltage = 1'b0;
  logic sleep_in_n, fault_out_n, bridge_hiz, pump_enable, irq, p_fault, p_hiz, p_act;
  logic active_openload_check, passive_openload_check, p_irq, p_pas, p_pump;
  logic [7:0] reg_rdata, p_rdata;
  logic [1:0] hf, ph;
  int fails = 0;
  int check_count = 0;
  assign hf = {bridge_hiz, fault_out_n};
  assign ph = {p_hiz, p_fault};
  bfm_host_model host (.clock, .rst, .go, .len, .sleep_in_n);
  bfm_fault_manager #(.RETRY_CYCLES(20), .DEGLITCH_CYCLES(4), .PULSE_MAX_CYCLES(16)) uut (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sleep_in_n,
    .openload_disable_pin, .pwm_pulse_done, .overshoot_seen, .passive_openload_detect,
    .over_temp, .over_temp_warn, .over_current, .pump_undervoltage, .supply_undervoltage,
    .fault_out_n, .bridge_hiz, .pump_enable, .active_openload_check,
    .passive_openload_check, .irq);
  bfm_fault_manager #(.PIN_VARIANT(1'b1), .RETRY_CYCLES(20), .DEGLITCH_CYCLES(4),
    .PULSE_MAX_CYCLES(16)) uut_pin (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata(p_rdata), .sleep_in_n, .openload_disable_pin, .pwm_pulse_done,
    .overshoot_seen, .passive_openload_detect, .over_temp, .over_temp_warn, .over_current,
    .pump_undervoltage, .supply_undervoltage, .fault_out_n(p_fault), .bridge_hiz(p_hiz),
    .pump_enable(p_pump), .active_openload_check(p_act), .passive_openload_check(p_pas),
    .irq(p_irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
  endtask
  task automatic pwm(input logic [4:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      pwm_pulse_done <= 1'b1;
      overshoot_seen <= pat[i];
    end
    @(posedge clock);
    pwm_pulse_done <= 1'b0;
    cyc(4);
  endtask
  task automatic sleep(input logic [7:0] l);
    @(posedge clock);
    go <= 1'b1;
    len <= l;
    @(posedge clock);
    go <= 1'b0;
    cyc(30);
  endtask
  task automatic t_reset();
    cyc(1);
    chk({fault_out_n, bridge_hiz, pump_enable, irq}, 4'ha);
    chk(active_openload_check, 1'b0);
    chk(p_act, 1'b0);
    @(posedge clock) openload_disable_pin <= 1'b0;
    cyc(3);
    chk(p_act, 1'b1);
    @(posedge clock) openload_disable_pin <= 1'b1;
    rd(CFG);
    chk(reg_rdata, bfm_pkg::CONFIG_RESET);
    rd(4'hf);
    chk(reg_rdata, 8'h00);
  endtask
  task automatic t_thermal();
    @(posedge clock) over_temp <= 1'b1;
    cyc(2);
    chk({hf, pump_enable, p_hiz}, 4'hb);
    wr(CFG, 8'h80);
    cyc(3);
    chk(bridge_hiz, 1'b1);
    @(posedge clock) over_temp <= 1'b0;
    cyc(3);
    chk(hf, 2'b10);
    chk(ph, 2'b01);
    rd(CND);
    chk(p_rdata[bfm_pkg::F_TSD], 1'b1);
    wr(CFG, 8'h80);
    cyc(3);
    chk(hf, 2'b01);
  endtask
  task automatic t_warn();
    @(posedge clock) over_temp_warn <= 1'b1;
    cyc(3);
    chk(hf, 2'b01);
    rd(CND);
    chk(reg_rdata[bfm_pkg::F_OTW], 1'b1);
    wr(CFG, 8'h02);
    cyc(2);
    chk(hf, 2'b00);
    @(posedge clock) over_temp_warn <= 1'b0;
    cyc(3);
    chk(fault_out_n, 1'b1);
    wr(CFG, 8'h00);
  endtask
  task automatic t_pump();
    @(posedge clock) pump_undervoltage <= 1'b1;
    cyc(2);
    chk(hf, 2'b10);
    @(posedge clock) pump_undervoltage <= 1'b0;
    cyc(2);
    chk(bridge_hiz, 1'b0);
    wr(CFG, 8'h84);
    @(posedge clock) pump_undervoltage <= 1'b1;
    cyc(3);
    chk(hf, 2'b01);
    @(posedge clock) pump_undervoltage <= 1'b0;
    wr(CFG, 8'h00);
  endtask
  task automatic t_openload();
    pwm(5'h00, 3);
    chk(fault_out_n, 1'b1);
    wr(bfm_pkg::ADDR_CTRL4, 8'h01);
    cyc(2);
    chk(active_openload_check, 1'b1);
    pwm(5'h04, 5);
    chk(fault_out_n, 1'b1);
    pwm(5'h00, 1);
    chk(fault_out_n, 1'b0);
    chk(irq, 1'b0);
    wr(bfm_pkg::ADDR_MASK, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    wr(bfm_pkg::ADDR_STATUS, 8'h01);
    cyc(2);
    chk({irq, fault_out_n}, 2'b00);
    wr(CFG, 8'h80);
    cyc(3);
    chk(fault_out_n, 1'b1);
    pwm(5'h00, 3);
    chk(fault_out_n, 1'b0);
    sleep(8'h02);
    chk(fault_out_n, 1'b0);
    sleep(8'h08);
    chk(fault_out_n, 1'b1);
    wr(bfm_pkg::ADDR_CTRL4, 8'h00);
    wr(bfm_pkg::ADDR_MASK, 8'h00);
  endtask
  task automatic t_passive();
    @(posedge clock) passive_openload_detect <= 1'b1;
    @(posedge clock) passive_openload_detect <= 1'b0;
    cyc(3);
    chk({fault_out_n, p_fault, p_pas}, 3'b010);
    chk({p_pump, p_irq}, 2'b10);
    wr(CFG, 8'h80);
    cyc(3);
    chk(fault_out_n, 1'b1);
  endtask
  task automatic t_ocp();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(CFG, {3'h0, m, 3'h0});
      @(posedge clock) over_current <= 1'b1;
      cyc(2);
      chk(hf, {m < 2'h2, m == 2'h3});
      @(posedge clock) over_current <= 1'b0;
      cyc(3);
      chk(hf, {m < 2'h2, m == 2'h3});
      cyc(25);
      chk(hf, {m == 2'h0, m[0]});
      wr(CFG, {3'h4, m, 3'h0});
      cyc(3);
      chk(hf, 2'b01);
    end
    wr(CFG, 8'h00);
  endtask
  task automatic t_supply_undervoltage_flag();
    @(posedge clock) supply_undervoltage <= 1'b1;
    cyc(2);
    chk(hf, 2'b10);
    @(posedge clock) supply_undervoltage <= 1'b0;
    cyc(3);
    chk(hf, 2'b01);
  endtask
  initial begin
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_thermal();
    t_warn();
    t_pump();
    t_openload();
    t_ocp();
    t_supply_undervoltage_flag();
    t_passive();
    end_of_test();
  end
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule

// File: verif/bfm_host_model.sv
`timescale 1ns/1ps
module bfm_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] len,
  output logic sleep_in_n
);
  logic [7:0] left;
  // sleep pin held low for len cycles after go, otherwise high
  always_ff @(posedge clock) begin
    if (rst) left <= 8'h00;
    else if (go) left <= len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  assign sleep_in_n = (left == 8'h00);
endmodule

// File: verif/bfm_monitor.sv
`timescale 1ns/1ps
module bfm_monitor #(
  parameter bit PIN_VARIANT = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic openload_disable_pin,
  input wire logic pwm_pulse_done,
  input wire logic overshoot_seen,
  input wire logic over_temp,
  input wire logic pump_undervoltage,
  input wire logic supply_undervoltage,
  input wire logic fault_out_n,
  input wire logic bridge_hiz,
  input wire logic pump_enable,
  input wire logic active_openload_check,
  input wire logic passive_openload_check
);
  logic [7:0] cfg_q;
  // shadow of the config register, for the pump check mode
  always_ff @(posedge clock) begin
    if (rst) cfg_q <= bfm_pkg::CONFIG_RESET;
    else if (reg_write && reg_addr == bfm_pkg::ADDR_CONFIG) cfg_q <= reg_wdata;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_miss;
    pwm_pulse_done && !overshoot_seen && active_openload_check;
  endsequence
  sequence s_three;
    s_miss ##1 s_miss ##1 s_miss;
  endsequence
  a_pump_stays_on: assert property (pump_enable)
    else $error("charge pump dropped");
  a_thermal_off_bridge: assert property (over_temp |=> bridge_hiz && !fault_out_n)
    else $error("over temperature not acted on");
  a_ola_three_miss: assert property (s_three |-> ##[1:4] !fault_out_n)
    else $error("open load not reported");
  a_ola_enable_write: assert property (!PIN_VARIANT && $rose(active_openload_check)
    |-> $past(reg_write) || $past(reg_write, 2)) else $error("open load check self enabled");
  a_pin_disable_checks: assert property ((PIN_VARIANT && openload_disable_pin) [*2]
    |-> !active_openload_check && !passive_openload_check) else $error("checks still on");
  a_uv_bridge_off: assert property (supply_undervoltage |=> bridge_hiz && !fault_out_n)
    else $error("supply undervoltage not acted on");
  a_pump_uv_report: assert property (pump_undervoltage
    && (PIN_VARIANT || !cfg_q[bfm_pkg::C_PUMP_UV_CHECK_DISABLE]) |=> bridge_hiz && !fault_out_n)
    else $error("pump undervoltage not acted on");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
bind bfm_fault_manager bfm_monitor #(.PIN_VARIANT(PIN_VARIANT)) mon (.clock, .rst,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .openload_disable_pin,
  .pwm_pulse_done, .overshoot_seen, .over_temp, .pump_undervoltage, .supply_undervoltage,
  .fault_out_n, .bridge_hiz, .pump_enable, .active_openload_check, .passive_openload_check);
